// ===== logic/ioc_overcurrent_trip.sv
// Behaviour
// - The any-phase trip is high exactly while at least one phase trip is high.
// - Operation is off, peak or fundamental, and is off after reset.
// - The start current is held in percent of nominal, 20 to 3000, default 200.
// - A phase whose measure exceeds the effective start current trips with no added delay.
// - While inhibit is high no phase trip and no any-phase trip is raised.
// - While setting-double is high the measure is compared with twice the start current.
// - Each phase has its own trip output driven by that phase alone.
// - Each change of a phase trip or of the any-phase trip raises an on or off event.
// - In peak mode a trip at twice the setting comes within 15 ms, release within 40 ms.
// - Phase trip status follows the comparison directly, with no timer stage.
// - Each phase derives its own peak magnitude from its samples for peak mode.
`timescale 1ns/10ps
module ioc_overcurrent_trip import ioc_pkg::*; #(
    parameter int PEAK_WIN = PEAK_WIN_DEF,
    parameter int OPERATE_CYC_P = OPERATE_CYC,
    parameter int RELEASE_CYC_P = RELEASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic sampleValid,
    input wire ioc_cur3_t sampleIn,
    input wire ioc_cur3_t fundRms,
    input wire logic inhibitIn,
    input wire logic doubleIn,
    output ioc_trips_t trips,
    output ioc_trips_t onEvt,
    output ioc_trips_t offEvt,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        logic inhMeta;
        logic inhSync;
        logic dblMeta;
        logic dblSync;
        ioc_op_t mode;
        logic [TH_W-1:0] startTh;
        ioc_trips_t trips;
        ioc_trips_t onEvt;
        ioc_trips_t offEvt;
        logic [7:0] evtSticky;
        logic [7:0] evtMask;
        logic irq;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ioc_state_t;

    localparam ioc_state_t ST_RST = '{mode: OP_OFF, startTh: TH_RESET, default: '0};

    ioc_state_t st_r;
    ioc_state_t st_nxt;
    ioc_cur3_t peakVal;
    ioc_cur3_t measure;
    logic [2:0] tripRaw;
    logic [CUR_W-1:0] effTh;

    function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign effTh = st_r.dblSync ? {3'h0, st_r.startTh, 1'b0} : {4'h0, st_r.startTh};

    for (genvar i = 0; i < 3; i++) begin : g_phase
        ioc_peak_select #(.PEAK_WIN(PEAK_WIN)) u_peak (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .clkEn(clkEn),
            .sampleValid(sampleValid),
            .sample(sampleIn[i]),
            .peakValue(peakVal[i])
        );
        // Fundamental RMS arrives ready-made from upstream logic
        assign measure[i] = (st_r.mode == OP_PEAK) ? peakVal[i] : fundRms[i];
        // Plain comparison, no timer
        assign tripRaw[i] = (st_r.mode != OP_OFF) && !st_r.inhSync && (measure[i] > effTh);

        a_phase_pickup: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            clkEn && st_r.mode == OP_FUND && !st_r.inhSync && fundRms[i] > effTh
            |=> trips.phaseTrip[i])
            else $error("phase did not trip above threshold");

        a_phase_drop: assert property (
            @(posedge ref_clk) disable iff (!rst_n)
            clkEn && st_r.mode == OP_FUND && fundRms[i] <= effTh |=> !trips.phaseTrip[i])
            else $error("phase trip held at or below threshold");
    end

    always_comb begin
        logic [31:0] merged;
        logic [7:0] evtClr;
        logic [ADDR_W-1:0] wa;
        logic [ADDR_W-1:0] ra;
        merged = '0;
        evtClr = '0;
        st_nxt = st_r;
        wa = {st_r.awAddr[ADDR_W-1:2], 2'h0};
        ra = {s_axi_araddr[ADDR_W-1:2], 2'h0};

        // Inhibit and double come from outside the clock domain
        st_nxt.inhMeta = inhibitIn;
        st_nxt.inhSync = st_r.inhMeta;
        st_nxt.dblMeta = doubleIn;
        st_nxt.dblSync = st_r.dblMeta;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
            wa = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_nxt.awHeld && st_nxt.wHeld && !st_r.bvalid) begin
            st_nxt.bresp = RESP_OKAY;
            if (wa == ADDR_CTRL) begin
                merged = applyStrb({30'h0, st_r.mode}, st_nxt.wData, st_nxt.wStrb);
                st_nxt.mode = (merged[1:0] == 2'h3) ? OP_OFF : ioc_op_t'(merged[1:0]);
            end else if (wa == ADDR_START) begin
                merged = applyStrb({20'h0, st_r.startTh}, st_nxt.wData, st_nxt.wStrb);
                // Out-of-range settings are clamped to the legal span
                if (merged < {20'h0, TH_MIN}) begin
                    st_nxt.startTh = TH_MIN;
                end else if (merged > {20'h0, TH_MAX}) begin
                    st_nxt.startTh = TH_MAX;
                end else begin
                    st_nxt.startTh = merged[TH_W-1:0];
                end
            end else if (wa == ADDR_STATUS) begin
                st_nxt.bresp = RESP_OKAY;
            end else if (wa == ADDR_EVENT) begin
                merged = applyStrb(32'h0, st_nxt.wData, st_nxt.wStrb);
                evtClr = merged[7:0];
            end else if (wa == ADDR_MASK) begin
                merged = applyStrb({24'h0, st_r.evtMask}, st_nxt.wData, st_nxt.wStrb);
                st_nxt.evtMask = merged[7:0];
            end else begin
                st_nxt.bresp = RESP_SLVERR;
            end
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bvalid = 1'b1;
        end
        st_nxt.awready = !st_nxt.awHeld && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.wHeld && !st_nxt.bvalid;

        // Read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            if (ra == ADDR_CTRL) begin
                st_nxt.rdata = {30'h0, st_r.mode};
            end else if (ra == ADDR_START) begin
                st_nxt.rdata = {20'h0, st_r.startTh};
            end else if (ra == ADDR_STATUS) begin
                st_nxt.rdata = {26'h0, st_r.dblSync, st_r.inhSync, st_r.trips};
            end else if (ra == ADDR_EVENT) begin
                st_nxt.rdata = {24'h0, st_r.evtSticky};
            end else if (ra == ADDR_MASK) begin
                st_nxt.rdata = {24'h0, st_r.evtMask};
            end else begin
                st_nxt.rdata = '0;
                st_nxt.rresp = RESP_SLVERR;
            end
        end
        st_nxt.arready = !st_nxt.rvalid;

        // Trip outputs and their edge events
        st_nxt.trips.phaseTrip = tripRaw;
        st_nxt.trips.anyPhase = |tripRaw;
        st_nxt.onEvt = ioc_trips_t'(st_nxt.trips & ~st_r.trips);
        st_nxt.offEvt = ioc_trips_t'(~st_nxt.trips & st_r.trips);
        // A new event outranks a clear in the same cycle
        st_nxt.evtSticky = (st_r.evtSticky & ~evtClr) | {st_nxt.offEvt, st_nxt.onEvt};
        st_nxt.irq = |(st_nxt.evtSticky & st_nxt.evtMask);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign trips = st_r.trips;
    assign onEvt = st_r.onEvt;
    assign offEvt = st_r.offEvt;
    assign irq = st_r.irq;
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rvalid = st_r.rvalid;

    // Watch counters for the operate and release limits
    int opCnt;
    int relCnt;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            opCnt <= 0;
            relCnt <= 0;
        end else if (clkEn) begin
            if (st_r.mode == OP_PEAK && !st_r.inhSync && !trips.anyPhase
                && peakVal[0] >= {effTh[CUR_W-2:0], 1'b0}) begin
                opCnt <= opCnt + 1;
            end else begin
                opCnt <= 0;
            end
            if (trips.anyPhase && !(|tripRaw)) begin
                relCnt <= relCnt + 1;
            end else begin
                relCnt <= 0;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_any_phase_or: assert property (
        trips.anyPhase == (|trips.phaseTrip))
        else $error("any-phase trip differs from OR of phases");

    a_off_forces_low: assert property (
        clkEn && st_r.mode == OP_OFF |=> trips == '0 && onEvt == '0)
        else $error("trip raised while operation is off");

    a_start_in_range: assert property (
        st_r.startTh >= TH_MIN && st_r.startTh <= TH_MAX)
        else $error("start current outside legal range");

    a_inhibit_blocks: assert property (
        clkEn && st_r.inhSync |=> trips == '0)
        else $error("trip raised while inhibited");

    a_double_threshold: assert property (
        clkEn && st_r.mode == OP_FUND && st_r.dblSync
        && fundRms[1] <= {3'h0, st_r.startTh, 1'b0} |=> !trips.phaseTrip[1])
        else $error("doubled threshold not applied");

    a_event_on_off: assert property (
        clkEn && st_nxt.trips != st_r.trips
        |=> (onEvt | offEvt) == (trips ^ $past(trips)))
        else $error("trip change without matching event");

    a_operate_time: assert property (
        opCnt < OPERATE_CYC_P)
        else $error("peak trip slower than operate limit");

    a_release_time: assert property (
        relCnt < RELEASE_CYC_P)
        else $error("trip release slower than reset limit");

    a_bresp_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
endmodule // ioc_overcurrent_trip

// ===== logic/ioc_pkg.sv
package ioc_pkg;
    // Currents and the start setting share one unit: percent of nominal
    localparam int CUR_W = 16;
    localparam int TH_W = 12;
    localparam int ADDR_W = 8;
    localparam logic [TH_W-1:0] TH_MIN = 12'h014;
    localparam logic [TH_W-1:0] TH_MAX = 12'hbb8;
    localparam logic [TH_W-1:0] TH_RESET = 12'h0c8;

    localparam int CLK_HZ = 25_000_000;
    localparam int OPERATE_TIME_MS = 15;
    localparam int RELEASE_TIME_MS = 40;
    // Longest times, rounded down to whole cycles
    localparam int OPERATE_CYC = (CLK_HZ / 1000) * OPERATE_TIME_MS;
    localparam int RELEASE_CYC = (CLK_HZ / 1000) * RELEASE_TIME_MS;
    localparam int PEAK_WIN_DEF = 20;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_START = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_OFF, OP_PEAK, OP_FUND} ioc_op_t;

    typedef struct packed {
        logic anyPhase;
        logic [2:0] phaseTrip;
    } ioc_trips_t;

    typedef logic [2:0][CUR_W-1:0] ioc_cur3_t;
endpackage

// ===== logic/ioc_peak_select.sv
`timescale 1ns/10ps
module ioc_peak_select import ioc_pkg::*; #(
    parameter int PEAK_WIN = PEAK_WIN_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic sampleValid,
    input wire logic [CUR_W-1:0] sample,
    output logic [CUR_W-1:0] peakValue
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [CUR_W-1:0] run;
        logic [CUR_W-1:0] held;
        logic [CUR_W-1:0] peak;
    } ioc_peak_st_t;

    ioc_peak_st_t st_r;
    ioc_peak_st_t st_nxt;
    logic [CUR_W-1:0] absVal;

    // Samples are two's complement; the most negative one maps to its magnitude
    assign absVal = sample[CUR_W-1] ? CUR_W'(~sample + 1'b1) : sample;

    always_comb begin
        logic [CUR_W-1:0] runNew;
        runNew = st_r.run;
        st_nxt = st_r;
        if (sampleValid) begin
            runNew = (absVal > st_r.run) ? absVal : st_r.run;
            if (st_r.cnt == 16'(PEAK_WIN - 1)) begin
                st_nxt.cnt = '0;
                st_nxt.held = runNew;
                st_nxt.run = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'h0001;
                st_nxt.run = runNew;
            end
        end
        // Rising current seen at once, falling current after one to two windows
        st_nxt.peak = (runNew > st_nxt.held) ? runNew : st_nxt.held;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign peakValue = st_r.peak;

    a_peak_covers_sample: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clkEn && sampleValid |=> peakValue >= $past(absVal))
        else $error("peak below latest sample magnitude");
endmodule // ioc_peak_select

// ===== tb/ioc_meas_model.sv
`timescale 1ns/10ps
module ioc_meas_model import ioc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire ioc_cur3_t level,
    output logic sampleValid,
    output ioc_cur3_t sampleIn,
    output ioc_cur3_t fundRms
);
    logic sign_r;
    // Samples alternate sign so each peak equals the commanded level
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sign_r <= 1'b0;
            sampleValid <= 1'b0;
            sampleIn <= '0;
            fundRms <= '0;
        end else begin
            sign_r <= ~sign_r;
            sampleValid <= 1'b1;
            fundRms <= level;
            for (int i = 0; i < 3; i++) begin
                sampleIn[i] <= sign_r ? -level[i] : level[i];
            end
        end
    end
endmodule // ioc_meas_model

// ===== tb/three_phase_instant_overcurrent_trip_tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    numChecks++; \
    if ((got) !== (exp)) begin \
        nMismatch++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module three_phase_instant_overcurrent_trip_tb_top import ioc_pkg::*;;
    localparam int OP_CYC = 64;
    localparam int REL_CYC = 256;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic inhibitIn = 1'b0;
    logic doubleIn = 1'b0;
    ioc_cur3_t level = '0;
    logic sampleValid;
    ioc_cur3_t sampleIn, fundRms;
    ioc_trips_t trips, onEvt, offEvt;
    logic irq;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int nMismatch = 0;
    int numChecks = 0;
    int cyc = 0;
    logic [31:0] rnd = 32'h95504c0d;
    logic [31:0] d;
    logic [1:0] r;
    logic [1:0] b;
    logic clkEn = 1'b1;
    logic [7:0] evtSeen = '0;
    logic evtWipe = 1'b0;
    int th, eff, n;
    logic [1:0] md;
    logic dbl, inh;
    ioc_cur3_t lv;
    ioc_trips_t et;
    int cv[4] = '{10, 20, 3000, 4000};

    ioc_meas_model meas (.ref_clk(ref_clk), .rst_n(rst_n), .level(level),
        .sampleValid(sampleValid), .sampleIn(sampleIn), .fundRms(fundRms));

    ioc_overcurrent_trip #(.PEAK_WIN(4), .OPERATE_CYC_P(OP_CYC), .RELEASE_CYC_P(REL_CYC)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .sampleValid(sampleValid),
        .sampleIn(sampleIn), .fundRms(fundRms), .inhibitIn(inhibitIn), .doubleIn(doubleIn),
        .trips(trips), .onEvt(onEvt), .offEvt(offEvt), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic ioc_trips_t expT(ioc_op_t m, int t, logic db, logic ih, ioc_cur3_t c);
        ioc_trips_t x;
        x = '0;
        for (int i = 0; i < 3; i++) begin
            x.phaseTrip[i] = (m != OP_OFF) && !ih && (int'(c[i]) > (db ? 2 * t : t));
        end
        x.anyPhase = |x.phaseTrip;
        return x;
    endfunction

    function automatic logic [11:0] clampV(int v);
        return 12'(v < 20 ? 20 : (v > 3000 ? 3000 : v));
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        b = bresp;
        bready <= 1'b0;
        if (k >= 50) nMismatch++;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        int k;
        k = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (k >= 50) nMismatch++;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Collects every event pulse the block raises
    always @(posedge ref_clk) begin
        evtSeen <= evtWipe ? 8'h00 : (evtSeen | {offEvt, onEvt});
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(ADDR_CTRL);
        `CHK(d, 32'h0)
        rd(ADDR_START);
        `CHK(d, 32'hc8)
        rd(8'h20);
        `CHK(r, RESP_SLVERR)
        wr(8'h20, 32'h1);
        `CHK(b, RESP_SLVERR)
        foreach (cv[i]) begin
            wr(ADDR_START, 32'(cv[i]));
            rd(ADDR_START);
            `CHK(d[11:0], clampV(cv[i]))
        end
        level <= {3{16'h1388}};
        repeat (16) @(posedge ref_clk);
        `CHK(trips, 4'h0)
        for (int k = 0; k < 60; k++) begin
            rnd = nxt(rnd);
            md = rnd[1:0];
            th = 20 + int'(rnd[31:20]) % 2981;
            wr(ADDR_CTRL, {30'h0, md});
            wr(ADDR_START, 32'(th));
            rnd = nxt(rnd);
            dbl = rnd[0];
            inh = rnd[2:1] == 2'h0;
            eff = dbl ? 2 * th : th;
            for (int i = 0; i < 3; i++) begin
                rnd = nxt(rnd);
                lv[i] = 16'(int'(rnd[31:16]) % (4 * th));
            end
            if (rnd[4:3] == 2'h0) begin
                lv[0] = 16'(eff);
                lv[1] = 16'(eff + 1);
            end
            level <= lv;
            doubleIn <= dbl;
            inhibitIn <= inh;
            repeat (16) @(posedge ref_clk);
            et = expT(md == 2'h3 ? OP_OFF : ioc_op_t'(md), th, dbl, inh, lv);
            `CHK(trips, et)
            rd(ADDR_STATUS);
            `CHK(d[5:0], {dbl, inh, et})
        end
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_START, 32'hc8);
        inhibitIn <= 1'b0;
        doubleIn <= 1'b0;
        level <= '0;
        repeat (16) @(posedge ref_clk);
        wr(ADDR_EVENT, 32'hff);
        wr(ADDR_MASK, 32'h01);
        `CHK(b, RESP_OKAY)
        evtWipe <= 1'b1;
        @(posedge ref_clk);
        evtWipe <= 1'b0;
        level[0] <= 16'd201;
        repeat (4) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        rd(ADDR_EVENT);
        `CHK(d[7:0], 8'h09)
        level <= '0;
        repeat (4) @(posedge ref_clk);
        rd(ADDR_EVENT);
        `CHK(d[7:0], 8'h99)
        `CHK(evtSeen, 8'h99)
        wr(ADDR_EVENT, 32'h01);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        rd(ADDR_EVENT);
        `CHK(d[7:0], 8'h98)
        wr(ADDR_CTRL, 32'h1);
        level[1] <= 16'd400;
        n = 0;
        while (trips.phaseTrip[1] !== 1'b1 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n <= OP_CYC, 1'b1)
        `CHK(trips, 4'ha)
        level[1] <= 16'd0;
        n = 0;
        while (trips.phaseTrip[1] !== 1'b0 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(n <= REL_CYC, 1'b1)
        level[1] <= 16'd400;
        repeat (16) @(posedge ref_clk);
        // Clock enable low freezes the trips although the current falls
        clkEn <= 1'b0;
        level[1] <= 16'd0;
        repeat (16) @(posedge ref_clk);
        `CHK(trips, 4'ha)
        clkEn <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK(trips, 4'h0)
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(ADDR_CTRL);
        `CHK(d, 32'h0)
        summarize();
    end
endmodule // three_phase_instant_overcurrent_trip_tb_top
